// >>> rtl/cpu_bus_cycle_sequencer.sv
// Bus cycle sequencer: T1..T4 states, waits, halt, cascade acknowledge, reset
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Reset takes effect at once; its release is synchronised to the clock over two stages.
// - Reset aborts any cycle at once; strobes go inactive and float in the same state.
// - In reset lock, strap and upper address pins become pulled-up inputs.
// - Only the strap pin may be pulled low in reset; low selects isolation test.
// - Each ordinary bus cycle runs T1, T2, T3 in order, then T4 only if another cycle is pending.
// - Idle state is taken whenever no bus cycle is pending.
// - T3 repeats while programmed waits remain or, on external accesses, ready is missing.
// - After T3 go to T4 if a cycle is pending, otherwise to idle.
// - Only T3, idle and hold repeat; T1, T2, T4 last one state.
// - One read shape and one write shape; kinds differ in address and status.
// - Halt floats data bus after a read, else drives; no strobes.
// - Cascade acknowledge runs two cycles, address invalid, no read or write.
// - Each internal register occupies one 16-bit word.
// - Software writes zero to undefined bits; read value not guaranteed.
// - Internal register access still runs an external cycle, no chip select.
// - Internal register reads ignore the external data bus.
// - Internal accesses take zero waits, timer registers take one.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "bus_seq_cfg.svh"
module cpu_bus_cycle_sequencer #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Core side request
  input wire logic req_valid,
  output logic req_ready,
  input wire bus_seq_pkg::cycle_kind_t req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic req_internal,
  input wire logic req_timer,
  input wire logic [3:0] req_cs_waits,
  input wire logic req_pending_next,
  input wire logic [DATA_W-1:0] internal_rdata,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Pins
  input wire logic ready_in,
  input wire logic bus_request_in,
  output logic bus_grant_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic rd_n_oe,
  output logic wr_n_out,
  output logic wr_n_oe,
  output logic data_buffer_enable_n,
  output logic den_oe,
  output logic chip_select_en,
  output logic [2:0] status_out,
  input wire logic [DATA_W-1:0] ad_in,
  output logic [DATA_W-1:0] ad_out,
  output logic ad_oe,
  output logic [3:0] upper_addr_out,
  output logic upper_addr_oe,
  input wire logic addr19_test_strap,
  output logic lock_oe,
  output logic isolation_test_mode,
  output logic bus_state_idle
);
  initial begin
    if (DATA_W != 16 || ADDR_W != 20) begin
      $error("Bus widths must be 16 data and 20 address");
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser; asserts at once, releases only after two clock edges
  logic [1:0] rst_sync_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  logic rst_int_n;
  assign rst_int_n = rst_sync_reg[1];
  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: three stages; ready and hold request change when stages 2 and 3 agree, the strap copy is unused
  logic [2:0] rdy_sync_reg;
  logic [2:0] hreq_sync_reg;
  logic [2:0] strap_sync_reg;
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rdy_sync_reg <= 3'h0;
      hreq_sync_reg <= 3'h0;
      strap_sync_reg <= 3'h7;
    end else if (clk_en) begin
      rdy_sync_reg <= {rdy_sync_reg[1:0], ready_in};
      hreq_sync_reg <= {hreq_sync_reg[1:0], bus_request_in};
      strap_sync_reg <= {strap_sync_reg[1:0], addr19_test_strap};
    end
  end
  function automatic logic agreed(input logic [2:0] s, input logic prev);
    agreed = (s[2] == s[1]) ? s[2] : prev;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Strap capture: sampled while the raw reset is low, held after release
  logic strap_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strap_reg <= addr19_test_strap;
    end
  end
  assign isolation_test_mode = !strap_reg;
  //////////////////////////////////////////////////////////////////////////////
  // Wait counter
  bus_req_if w ();
  wait_counter u_wait (
    .core_clk(core_clk),
    .rst_int_n(rst_int_n),
    .clk_en(clk_en),
    .w(w)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  typedef struct packed {
    bus_seq_pkg::bus_state_t st;
    bus_seq_pkg::cycle_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic internal;
    logic last_read;
    logic [1:0] inta_left;
    logic rdy;
    logic hreq;
    logic rsp;
    logic started;
  } seq_state_t;
  seq_state_t s_reg;
  seq_state_t s_next;
  function automatic logic is_read(input bus_seq_pkg::cycle_kind_t k);
    is_read = (k == bus_seq_pkg::CYC_MEM_RD) || (k == bus_seq_pkg::CYC_IO_RD) ||
      (k == bus_seq_pkg::CYC_FETCH) || (k == bus_seq_pkg::CYC_REFRESH);
  endfunction
  function automatic logic is_write(input bus_seq_pkg::cycle_kind_t k);
    is_write = (k == bus_seq_pkg::CYC_MEM_WR) || (k == bus_seq_pkg::CYC_IO_WR);
  endfunction
  logic take;
  logic waits_done;
  assign waits_done = w.done;
  always_comb begin
    s_next = s_reg;
    s_next.rsp = 1'b0;
    s_next.rdy = agreed(rdy_sync_reg, s_reg.rdy);
    s_next.hreq = agreed(hreq_sync_reg, s_reg.hreq);
    w.load = 1'b0;
    w.count = 4'h0;
    w.tick = 1'b0;
    take = 1'b0;
    case (s_reg.st)
      bus_seq_pkg::ST_IDLE: begin
        if (s_reg.hreq) begin
          s_next.st = bus_seq_pkg::ST_HOLD;
        end else if (s_reg.inta_left != 2'h0) begin
          s_next.st = bus_seq_pkg::ST_T1;
        end else if (req_valid) begin
          take = 1'b1;
          s_next.kind = req_kind;
          s_next.addr = req_addr;
          s_next.wdata = req_wdata;
          s_next.internal = req_internal;
          s_next.inta_left = (req_kind == bus_seq_pkg::CYC_INTA) ? `INTA_CYCLES : 2'h0;
          s_next.st = bus_seq_pkg::ST_T1;
        end else begin
          s_next.st = bus_seq_pkg::ST_IDLE;
        end
      end
      bus_seq_pkg::ST_T1: begin
        s_next.st = bus_seq_pkg::ST_T2;
        w.load = 1'b1;
        if (req_internal_hold()) begin
          w.count = s_reg.internal && req_timer ? `TIMER_WAITS : `PERIPH_WAITS;
        end else begin
          w.count = req_cs_waits;
        end
      end
      bus_seq_pkg::ST_T2: begin
        s_next.st = bus_seq_pkg::ST_T3;
      end
      bus_seq_pkg::ST_T3: begin
        w.tick = 1'b1;
        if (waits_done && (s_reg.rdy || s_reg.internal)) begin
          if (is_read(s_reg.kind) || s_reg.kind == bus_seq_pkg::CYC_INTA) begin
            s_next.rdata = s_reg.internal ? internal_rdata : ad_in;
          end
          if (s_reg.kind == bus_seq_pkg::CYC_INTA) begin
            s_next.inta_left = s_reg.inta_left - 2'h1;
          end
          s_next.st = (req_pending_next || s_reg.inta_left == 2'h2)
            ? bus_seq_pkg::ST_T4 : bus_seq_pkg::ST_IDLE;
          s_next.rsp = (s_reg.kind != bus_seq_pkg::CYC_INTA) || (s_reg.inta_left == 2'h1);
          s_next.last_read = is_read(s_reg.kind);
        end else begin
          s_next.st = bus_seq_pkg::ST_T3;
        end
      end
      bus_seq_pkg::ST_T4: begin
        s_next.st = bus_seq_pkg::ST_IDLE;
      end
      bus_seq_pkg::ST_HOLD: begin
        if (!s_reg.hreq) begin
          s_next.st = bus_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        s_next.st = bus_seq_pkg::ST_IDLE;
      end
    endcase
  end
  // Internal accesses get fixed waits; chip select waits apply to external ones
  function automatic logic req_internal_hold();
    req_internal_hold = s_reg.internal;
  endfunction
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
  assign req_ready = take;
  //////////////////////////////////////////////////////////////////////////////
  // Pin drive; in reset every strobe is released so pullups hold the lines
  logic in_rst;
  logic rd_ph;
  logic wr_ph;
  logic data_ph;
  logic strobe_cyc;
  assign in_rst = !rst_int_n;
  assign rd_ph = (s_reg.st == bus_seq_pkg::ST_T2) || (s_reg.st == bus_seq_pkg::ST_T3);
  assign strobe_cyc = (s_reg.kind != bus_seq_pkg::CYC_HALT);
  assign wr_ph = rd_ph;
  assign data_ph = rd_ph && strobe_cyc;
  logic drive_bus;
  assign drive_bus = !in_rst && (s_reg.st != bus_seq_pkg::ST_HOLD);
  logic [DATA_W-1:0] ad_q;
  logic ad_oe_q;
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ad_q <= 16'h0000;
      ad_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (s_next.st == bus_seq_pkg::ST_T1) begin
        ad_q <= s_next.addr[DATA_W-1:0];
        // A halt after a read keeps the bus floating from its first state on
        ad_oe_q <= (s_next.kind == bus_seq_pkg::CYC_HALT) ? !s_next.last_read : 1'b1;
      end else if (s_next.st == bus_seq_pkg::ST_T2) begin
        ad_q <= s_reg.wdata;
        ad_oe_q <= s_reg.kind == bus_seq_pkg::CYC_HALT ? !s_reg.last_read
          : is_write(s_reg.kind);
      end else if (s_next.st == bus_seq_pkg::ST_HOLD) begin
        ad_oe_q <= 1'b0;
      end
    end
  end
  assign ad_out = ad_q;
  assign ad_oe = ad_oe_q && drive_bus;
  assign ale_out = drive_bus && s_reg.st == bus_seq_pkg::ST_T1;
  assign rd_n_out = !(drive_bus && rd_ph && is_read(s_reg.kind));
  assign wr_n_out = !(drive_bus && wr_ph && is_write(s_reg.kind));
  assign rd_n_oe = drive_bus;
  assign wr_n_oe = drive_bus;
  assign den_oe = drive_bus;
  assign data_buffer_enable_n = !(drive_bus && data_ph);
  assign chip_select_en = drive_bus && !s_reg.internal &&
    s_reg.kind != bus_seq_pkg::CYC_INTA;
  assign status_out = s_reg.kind;
  assign upper_addr_out = (s_reg.kind == bus_seq_pkg::CYC_INTA) ? 4'h0
    : s_reg.addr[ADDR_W-1:`UPPER_ADDR_LSB];
  assign upper_addr_oe = drive_bus;
  assign lock_oe = drive_bus;
  assign bus_grant_out = s_reg.st == bus_seq_pkg::ST_HOLD;
  assign bus_state_idle = s_reg.st == bus_seq_pkg::ST_IDLE;
  assign rsp_valid = s_reg.rsp;
  assign rsp_rdata = s_reg.rdata;
  logic unused_ok;
  assign unused_ok = strap_sync_reg[2];
endmodule

// >>> rtl/bus_seq_cfg.svh
// Constants for the bus cycle sequencer
`ifndef BUS_SEQ_CFG_SVH
`define BUS_SEQ_CFG_SVH
`define ADDR_W 20
`define DATA_W 16
`define RESET_SYNC_STAGES 2
`define TIMER_WAITS 4'h1
`define PERIPH_WAITS 4'h0
`define INTA_CYCLES 2'h2
`define UPPER_ADDR_LSB 16
`endif

// >>> rtl/bus_seq_pkg.sv
// Types shared by the bus cycle sequencer files
package bus_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_T4, ST_HOLD
  } bus_state_t;
  typedef enum logic [2:0] {
    CYC_MEM_RD, CYC_IO_RD, CYC_FETCH, CYC_REFRESH,
    CYC_MEM_WR, CYC_IO_WR, CYC_HALT, CYC_INTA
  } cycle_kind_t;
endpackage

// >>> rtl/bus_req_if.sv
// Request and answer group between the sequencer and its wait counter
`timescale 1ns/1ps
interface bus_req_if;
  logic load;
  logic [3:0] count;
  logic tick;
  logic done;
  modport seq (output load, output count, output tick, input done);
  modport cnt (input load, input count, input tick, output done);
endinterface

// >>> rtl/wait_counter.sv
// Wait state counter for T3 extension
`timescale 1ns/1ps
module wait_counter (
  input wire logic core_clk,
  input wire logic rst_int_n,
  input wire logic clk_en,
  bus_req_if.cnt w
);
  typedef struct packed {
    logic [3:0] left;
  } cnt_state_t;
  cnt_state_t s_reg;
  cnt_state_t s_next;
  always_comb begin
    s_next = s_reg;
    if (w.load) begin
      s_next.left = w.count;
    end else if (w.tick && s_reg.left != 4'h0) begin
      s_next.left = s_reg.left - 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end
  assign w.done = (s_reg.left == 4'h0);
endmodule

// >>> tb/cpu_bus_cycle_sequencer_assertions.sv
// Concurrent checks on the bus cycle sequencer pins
`timescale 1ns/1ps
module cpu_bus_cycle_sequencer_assertions (
  input wire logic core_clk, rst_n, req_ready, req_internal, req_timer, rsp_valid,
  input wire logic bus_grant_out, ale_out, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe, den_oe,
  input wire logic data_buffer_enable_n, chip_select_en, ad_oe, upper_addr_oe, lock_oe,
  input wire logic ready_in, bus_request_in, bus_state_idle,
  input wire logic [2:0] status_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Read kinds use codes 0 to 3, writes 4 and 5
  sequence s_t1(logic w);
    ale_out && status_out[2] == w && (!w || !status_out[1]);
  endsequence
  sequence s_t2(logic s, logic o);
    !ale_out && !s && o && !data_buffer_enable_n;
  endsequence
  // Grant is excluded: strobes float then, so their level means nothing
  sequence s_busy(logic [2:0] k);
    status_out == k && !bus_state_idle && !bus_grant_out;
  endsequence
  ////////////////////////////////////////
  a_read_shape: assert property (s_t1(1'b0) |=> s_t2(rd_n_out, wr_n_out))
    else $error("read cycle without its T2 strobe");
  a_write_shape: assert property (s_t1(1'b1) |=> s_t2(wr_n_out, rd_n_out))
    else $error("write cycle without its T2 strobe");
  a_t1_single: assert property (ale_out |=> !ale_out)
    else $error("address strobe longer than one state");
  a_halt_quiet: assert property (s_busy(3'h6) |-> rd_n_out && wr_n_out && data_buffer_enable_n)
    else $error("strobe during halt cycle");
  a_ack_quiet: assert property (s_busy(3'h7) |-> rd_n_out && wr_n_out && !chip_select_en)
    else $error("strobe during acknowledge cycle");
  a_internal_no_cs: assert property (req_ready && req_internal |=> !chip_select_en [*4])
    else $error("chip select on internal access");
  a_internal_fast: assert property (req_ready && req_internal && !req_timer |-> ##[4:5] rsp_valid)
    else $error("internal access not zero wait");
  a_ready_wait: assert property ((chip_select_en && !rd_n_out && !ready_in) [*4] |=> !rd_n_out)
    else $error("read ended without ready");
  a_grant_float: assert property (bus_grant_out |-> !ad_oe && !rd_n_oe && !wr_n_oe && !upper_addr_oe)
    else $error("bus driven while granted");
  a_take_idle: assert property (req_ready |-> bus_state_idle && !bus_request_in)
    else $error("request taken outside idle");
  a_reset_float: assert property (@(posedge core_clk) disable iff (1'b0)
    !rst_n |-> !(ad_oe || rd_n_oe || wr_n_oe || den_oe || lock_oe || upper_addr_oe || bus_grant_out))
    else $error("pin driven during reset");
endmodule
bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_assertions i_cpu_bus_cycle_sequencer_assertions (.*);

// >>> tb/bus_partner.sv
// Behavioural external memory and cascade interrupt controller
`timescale 1ns/1ps
module bus_partner #(
  parameter logic [15:0] VEC = 16'h005A
) (
  input wire logic core_clk,
  input wire logic ale_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  input wire logic [2:0] status_out,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe,
  input wire logic [7:0] dly,
  output logic ready_in,
  output logic [15:0] ad_in
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [3:0] a = 4'h0;
  int cnt = 0, acks = 0;
  ////////////////////////////////////////
  // A slow device holds ready low outside its strobes, so no stale ready reaches T3
  assign ready_in = (dly == 8'h00) || (cnt >= int'(dly) && !(rd_n_out && wr_n_out));
  // A released bus shows a changing pattern, never a held copy
  assign ad_in = ad_oe ? ad_out : status_out == 3'h7 ? (acks == 2 ? VEC : ~VEC) :
    rd_n_out ? ~last : mem[a];
  always @(posedge core_clk) begin
    last <= ad_in;
    cnt <= ale_out ? 0 : cnt + 1;
    if (ale_out) a <= ad_out[3:0];
    if (ale_out && status_out == 3'h7) acks <= acks % 2 + 1;
    if (!wr_n_out && ready_in) mem[a] <= ad_out;
  end
endmodule

// >>> tb/cpu_bus_cycle_sequencer_bench.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module cpu_bus_cycle_sequencer_bench;
  logic core_clk = 0, rst_n = 0, clk_en = 1, req_valid = 0, req_internal = 0, req_timer = 0;
  logic req_pending_next = 0, bus_request_in = 0, addr19_test_strap = 1, ready_in;
  logic req_ready, rsp_valid, bus_grant_out, ale_out, rd_n_out, rd_n_oe, wr_n_out, wr_n_oe;
  logic data_buffer_enable_n, den_oe, chip_select_en, ad_oe, upper_addr_oe, lock_oe;
  logic isolation_test_mode, bus_state_idle, rw, cs, stb, oes;
  logic [2:0] status_out;
  logic [3:0] upper_addr_out, req_cs_waits = 4'h0;
  logic [7:0] dly = 8'h00;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000, internal_rdata = 16'h0000, rsp_rdata, ad_in, ad_out;
  bus_seq_pkg::cycle_kind_t req_kind = bus_seq_pkg::CYC_MEM_RD;
  int num_errors = 0, compares = 0, lat = 0, base = 0, ales = 0;
  cpu_bus_cycle_sequencer i_cpu_bus_cycle_sequencer (.*);
  bus_partner i_bus_partner (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (ale_out === 1'b1) ales++;
  ////////////////////////////////////////
  task automatic test_done();
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic stuck();
    num_errors++;
    test_done();
  endtask
  // Held until taken, then watched to its answer; strobes seen are gathered
  task automatic run(bus_seq_pkg::cycle_kind_t k, logic [19:0] a, logic [15:0] d,
      logic inr, logic tmr, logic [3:0] w);
    @(posedge core_clk);
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    internal_rdata <= ~d;
    req_internal <= inr;
    req_timer <= tmr;
    req_cs_waits <= w;
    req_pending_next <= a[0];
    req_valid <= 1'b1;
    lat = 0;
    do begin
      @(negedge core_clk);
      if (++lat > 300) stuck();
    end while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    {rw, cs, stb, oes} = 4'h0;
    lat = 0;
    ales = 0;
    do begin
      @(negedge core_clk);
      rw |= !rd_n_out | !wr_n_out;
      stb |= !rd_n_out | !wr_n_out | !data_buffer_enable_n;
      cs |= chip_select_en;
      oes |= ad_oe;
      if (++lat > 300) stuck();
    end while (rsp_valid !== 1'b1);
  endtask
  task automatic do_reset(logic s);
    @(posedge core_clk);
    rst_n <= 1'b0;
    addr19_test_strap <= s;
    @(negedge core_clk);
    `CHK({rd_n_oe, wr_n_oe, ad_oe, lock_oe, upper_addr_oe}, 5'h00)
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    addr19_test_strap <= 1'b1;
    @(negedge core_clk);
    `CHK(isolation_test_mode, !s)
  endtask
  ////////////////////////////////////////
  task automatic test_rw();
    for (int i = 0; i < 4; i++) begin
      run(i[0] ? bus_seq_pkg::CYC_IO_WR : bus_seq_pkg::CYC_MEM_WR, 20'(i), 16'hA5C0 + 16'(i),
        1'b0, 1'b0, 4'h0);
      run(bus_seq_pkg::cycle_kind_t'(i), 20'(i), 16'h0000, 1'b0, 1'b0, 4'h0);
      `CHK(rsp_rdata, 16'hA5C0 + 16'(i))
      `CHK({rw, cs}, 2'h3)
      repeat (3) @(negedge core_clk);
      `CHK(bus_state_idle, 1'b1)
    end
  endtask
  task automatic test_timing();
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00002, 16'h0000, 1'b0, 1'b0, 4'h0);
    base = lat;
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00002, 16'h0000, 1'b0, 1'b0, 4'h3);
    `CHK(lat, base + 3)
    dly = 8'h06;
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00002, 16'h0000, 1'b0, 1'b0, 4'h0);
    `CHK(lat > base, 1'b1)
    dly = 8'h00;
  endtask
  // Waits of 15 are programmed so that an internal access that obeys them shows up
  task automatic test_internal();
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00001, 16'h3C5A, 1'b1, 1'b0, 4'hF);
    base = lat;
    `CHK(rsp_rdata, 16'hC3A5)
    `CHK(cs, 1'b0)
    run(bus_seq_pkg::CYC_IO_RD, 20'h00001, 16'h3C5A, 1'b1, 1'b1, 4'hF);
    `CHK(lat, base + 1)
  endtask
  task automatic test_special();
    run(bus_seq_pkg::CYC_INTA, 20'h00000, 16'h0000, 1'b0, 1'b0, 4'h0);
    `CHK(rsp_rdata, 16'h005A)
    `CHK(ales, 2)
    `CHK(rw, 1'b0)
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00000, 16'h0000, 1'b0, 1'b0, 4'h0);
    run(bus_seq_pkg::CYC_HALT, 20'h00000, 16'h0000, 1'b0, 1'b0, 4'h0);
    `CHK({oes, stb}, 2'h0)
    run(bus_seq_pkg::CYC_MEM_WR, 20'h00003, 16'h0F0F, 1'b0, 1'b0, 4'h0);
    run(bus_seq_pkg::CYC_HALT, 20'h00000, 16'h0000, 1'b0, 1'b0, 4'h0);
    `CHK({oes, stb}, 2'h2)
  endtask
  task automatic test_hold();
    @(posedge core_clk);
    bus_request_in <= 1'b1;
    lat = 0;
    do begin
      @(negedge core_clk);
      if (++lat > 50) stuck();
    end while (bus_grant_out !== 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b1;
    @(negedge core_clk);
    `CHK({ad_oe, req_ready}, 2'h0)
    @(posedge core_clk);
    bus_request_in <= 1'b0;
    run(bus_seq_pkg::CYC_MEM_RD, 20'h00002, 16'h0000, 1'b0, 1'b0, 4'h0);
    `CHK(rsp_rdata, 16'hA5C2)
  endtask
  // A slow device keeps the read in its wait states when reset arrives
  task automatic test_abort();
    dly = 8'h28;
    @(posedge core_clk);
    req_kind <= bus_seq_pkg::CYC_MEM_RD;
    req_valid <= 1'b1;
    repeat (5) @(posedge core_clk);
    req_valid <= 1'b0;
    do_reset(1'b1);
    dly = 8'h00;
  endtask
  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    test_rw();
    test_timing();
    test_internal();
    test_special();
    test_hold();
    test_abort();
    test_done();
  end
endmodule
